// file: lp_pd_pkg.sv
// constants, states and commands for the power-down sequencer
// Functional notes
// - power-down request is clock enable low with chip select high on a rising edge.
// - clock enable stays high while read, write or mode register operations run.
// - clock enable may drop during activate, precharge or refresh.
// - two no-operation cycles follow the clock-enable-low edge on entry.
// - clock enable stays low at least the minimum pulse time in power-down.
// - power-down is left early enough to keep refresh on schedule.
// - exit raises clock enable with chip select high, held for minimum pulse.
// - no valid command until exit latency after clock enable rises.
// - a stopped or changed clock runs stable two cycles before exit.
// - after read, clock enable low waits latency plus access plus half burst plus one.
// - after write, wait latency plus one, half burst, recovery; one more with auto precharge.
// - after refresh, activate or precharge, wait the clock-enable hold time.
// - mode register read spaced like read; mode register write waits its period.
// - deep power-down is clock enable low, chip select low, bits 0,1 high, bit 2 low.
// - deep power-down needs idle banks, clock enable held low, two no-operations.
// - deep power-down exit needs stable clock, then full initialization.
// - frequency change with clock enable low keeps old clock two cycles after drop.
// - clock stop with clock enable low holds true clock low, complement high.
// - frequency change with clock enable high needs all commands done, chip select high.
// - clock stop with clock enable high; ready two cycles plus exit latency after restart.
// - latency and recovery settings are reprogrammed after a frequency change.
// - no-operation is chip select high, only when clock enable is unchanged.
package lp_pd_pkg;
	localparam int TW = 8;
	localparam logic [7:0] BURST_HALF = 8'h04;
	localparam logic [7:0] CPDED_CYCLES = 8'h02;
	localparam logic [7:0] CLK_STABLE_CYCLES = 8'h02;
	localparam logic [2:0] DPD_CA = 3'h3;
	localparam logic [7:0] ONE = 8'h01;

	typedef enum logic [3:0] {
		CMD_NOP   = 4'h0,
		CMD_READ  = 4'h1,
		CMD_WRITE = 4'h2,
		CMD_WRA   = 4'h3,
		CMD_MRR   = 4'h4,
		CMD_MRW   = 4'h5,
		CMD_ACT   = 4'h6,
		CMD_PRE   = 4'h7,
		CMD_REF   = 4'h8
	} cmd_kind_e;

	typedef enum logic [3:0] {
		ST_ACTIVE     = 4'h0,
		ST_PD_ENTRY   = 4'h1,
		ST_PD         = 4'h2,
		ST_PD_EXIT    = 4'h3,
		ST_DPD_ENTRY  = 4'h4,
		ST_DPD        = 4'h5,
		ST_INIT_WAIT  = 4'h6,
		ST_CLK_OFF    = 4'h7,
		ST_CLK_ON     = 4'h8,
		ST_HI_STOP    = 4'h9,
		ST_HI_RESTART = 4'hA
	} pd_state_e;
endpackage : lp_pd_pkg

// file: cycle_timer.sv
// loadable down counter for phase delays
`timescale 1ns/1ps
module cycle_timer #(
	parameter int W = 8
) (
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	input  wire logic         load,
	input  wire logic [W-1:0] load_val,
	output logic              done
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;

	assign cnt_next = load ? load_val : ((cnt_reg != '0) ? cnt_reg - 1'b1 : cnt_reg);
	assign done = (cnt_reg == '0);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) cnt_reg <= '0;
		else cnt_reg <= cnt_next;
	end
endmodule : cycle_timer

// file: cke_spacing_tracker.sv
// tracks the earliest cycle at which clock enable may drop
`timescale 1ns/1ps
module cke_spacing_tracker (
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	input  wire logic       issue,
	input  wire logic [3:0] kind,
	input  wire logic [7:0] rl_cycles,
	input  wire logic [7:0] wl_cycles,
	input  wire logic [7:0] dqsck_cycles,
	input  wire logic [7:0] wr_cycles,
	input  wire logic [7:0] mrw_cycles,
	input  wire logic [7:0] ihcke_cycles,
	output logic            low_ok
);
	logic [7:0] cnt_reg;
	logic [7:0] cnt_next;
	logic [7:0] need;
	logic [7:0] load_val;
	logic [7:0] dec_val;

	// spacing from command edge to the edge that may register clock enable low
	function automatic logic [7:0] spacing(input logic [3:0] k, input logic [7:0] rl, input logic [7:0] wl,
		input logic [7:0] dq, input logic [7:0] wr, input logic [7:0] mrw, input logic [7:0] ih);
		logic [7:0] s;
		s = 8'h00;
		unique case (k)
			lp_pd_pkg::CMD_READ,
			lp_pd_pkg::CMD_MRR:   s = rl + dq + lp_pd_pkg::BURST_HALF + lp_pd_pkg::ONE;
			lp_pd_pkg::CMD_WRITE: s = wl + lp_pd_pkg::ONE + lp_pd_pkg::BURST_HALF + wr;
			lp_pd_pkg::CMD_WRA:   s = wl + lp_pd_pkg::ONE + lp_pd_pkg::BURST_HALF + wr + lp_pd_pkg::ONE;
			lp_pd_pkg::CMD_MRW:   s = mrw;
			lp_pd_pkg::CMD_ACT,
			lp_pd_pkg::CMD_PRE,
			lp_pd_pkg::CMD_REF:   s = ih;
			default:              s = 8'h00;
		endcase
		return s;
	endfunction : spacing

	assign need = spacing(kind, rl_cycles, wl_cycles, dqsck_cycles, wr_cycles, mrw_cycles, ihcke_cycles);
	assign load_val = (need != 8'h00) ? need - lp_pd_pkg::ONE : 8'h00;
	assign dec_val = (cnt_reg != 8'h00) ? cnt_reg - lp_pd_pkg::ONE : 8'h00;
	assign cnt_next = (issue && load_val > dec_val) ? load_val : dec_val;
	assign low_ok = (cnt_reg == 8'h00) && !issue;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) cnt_reg <= 8'h00;
		else cnt_reg <= cnt_next;
	end
endmodule : cke_spacing_tracker

// file: lp_power_seq.sv
// host-side power-down, deep power-down and clock-stop sequencer
`timescale 1ns/1ps
module lp_power_seq #(
	parameter int CA_W = 10
) (
	input  wire logic            sys_clk,
	input  wire logic            resetn,
	// command port
	input  wire logic            cmd_valid,
	input  wire logic [3:0]      cmd_kind,
	input  wire logic [CA_W-1:0] cmd_ca,
	output logic                 cmd_ready,
	// low-power requests
	input  wire logic            pd_req,
	input  wire logic            pd_exit_req,
	input  wire logic            dpd_req,
	input  wire logic            dpd_exit_req,
	input  wire logic            clk_stop_req,
	input  wire logic            refresh_due,
	input  wire logic            banks_idle,
	input  wire logic            init_done,
	// timing configuration in clock cycles
	input  wire logic [7:0]      rl_cycles,
	input  wire logic [7:0]      wl_cycles,
	input  wire logic [7:0]      dqsck_cycles,
	input  wire logic [7:0]      wr_cycles,
	input  wire logic [7:0]      mrw_cycles,
	input  wire logic [7:0]      ihcke_cycles,
	input  wire logic [7:0]      xp_cycles,
	input  wire logic [7:0]      cke_min_cycles,
	// memory pins
	output logic                 cke,
	output logic                 cs_n,
	output logic [CA_W-1:0]      ca,
	output logic                 ck_run,
	// status
	output logic                 in_power_down,
	output logic                 in_deep_power_down,
	output logic                 clock_stopped,
	output logic                 init_needed
);
	// ==========================================================
	// state and pin registers
	lp_pd_pkg::pd_state_e state_reg;
	lp_pd_pkg::pd_state_e state_next;
	logic                 cke_reg;
	logic                 cke_next;
	logic                 cs_n_reg;
	logic                 cs_n_next;
	logic [CA_W-1:0]      ca_reg;
	logic [CA_W-1:0]      ca_next;
	logic                 ck_run_reg;
	logic                 ck_run_next;
	logic                 ret_dpd_reg;
	logic                 ret_dpd_next;
	logic                 tmr_load;
	logic [7:0]           tmr_val;
	logic                 tmr_done;
	logic                 low_ok;
	logic                 issue;
	logic                 go_pd;
	logic                 go_dpd;
	logic                 go_hi_stop;
	logic                 want_exit;
	logic [7:0]           exit_wait;
	logic [CA_W-1:0]      dpd_code;

	// ==========================================================
	// helpers
	cycle_timer #(.W(lp_pd_pkg::TW)) u_timer (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.load     (tmr_load),
		.load_val (tmr_val),
		.done     (tmr_done)
	);

	cke_spacing_tracker u_track (
		.sys_clk      (sys_clk),
		.resetn       (resetn),
		.issue        (issue),
		.kind         (cmd_kind),
		.rl_cycles    (rl_cycles),
		.wl_cycles    (wl_cycles),
		.dqsck_cycles (dqsck_cycles),
		.wr_cycles    (wr_cycles),
		.mrw_cycles   (mrw_cycles),
		.ihcke_cycles (ihcke_cycles),
		.low_ok       (low_ok)
	);

	// ==========================================================
	// decode
	assign dpd_code = {{(CA_W-3){1'b0}}, lp_pd_pkg::DPD_CA};
	assign go_dpd = dpd_req && banks_idle && low_ok;
	assign go_pd = pd_req && !dpd_req && low_ok;
	assign go_hi_stop = clk_stop_req && !pd_req && !dpd_req && low_ok;
	assign cmd_ready = (state_reg == lp_pd_pkg::ST_ACTIVE) && !pd_req && !dpd_req && !clk_stop_req;
	assign issue = cmd_valid && cmd_ready;
	assign want_exit = pd_exit_req || refresh_due;
	assign exit_wait = (xp_cycles > cke_min_cycles) ? xp_cycles : cke_min_cycles;

	// ==========================================================
	// next state
	always_comb begin
		state_next = state_reg;
		cke_next = cke_reg;
		cs_n_next = 1'b1;
		ca_next = ca_reg;
		ck_run_next = ck_run_reg;
		ret_dpd_next = ret_dpd_reg;
		tmr_load = 1'b0;
		tmr_val = 8'h00;
		unique case (state_reg)
			lp_pd_pkg::ST_ACTIVE: begin
				if (go_dpd) begin
					cke_next = 1'b0;
					cs_n_next = 1'b0;
					ca_next = dpd_code;
					tmr_load = 1'b1;
					tmr_val = lp_pd_pkg::CPDED_CYCLES - lp_pd_pkg::ONE;
					state_next = lp_pd_pkg::ST_DPD_ENTRY;
				end else if (go_pd) begin
					cke_next = 1'b0;
					tmr_load = 1'b1;
					tmr_val = lp_pd_pkg::CPDED_CYCLES - lp_pd_pkg::ONE;
					state_next = lp_pd_pkg::ST_PD_ENTRY;
				end else if (go_hi_stop) begin
					ck_run_next = 1'b0;
					state_next = lp_pd_pkg::ST_HI_STOP;
				end else if (issue && cmd_kind != lp_pd_pkg::CMD_NOP) begin
					cs_n_next = 1'b0;
					ca_next = cmd_ca;
				end
			end
			lp_pd_pkg::ST_PD_ENTRY,
			lp_pd_pkg::ST_DPD_ENTRY: begin
				// chip select high no-operations while the entry delay runs
				if (tmr_done) begin
					tmr_load = 1'b1;
					tmr_val = cke_min_cycles;
					state_next = (state_reg == lp_pd_pkg::ST_DPD_ENTRY) ? lp_pd_pkg::ST_DPD : lp_pd_pkg::ST_PD;
				end
			end
			lp_pd_pkg::ST_PD: begin
				if (clk_stop_req) begin
					ck_run_next = 1'b0;
					ret_dpd_next = 1'b0;
					state_next = lp_pd_pkg::ST_CLK_OFF;
				end else if (tmr_done && want_exit) begin
					cke_next = 1'b1;
					tmr_load = 1'b1;
					tmr_val = exit_wait - lp_pd_pkg::ONE;
					state_next = lp_pd_pkg::ST_PD_EXIT;
				end
			end
			lp_pd_pkg::ST_DPD: begin
				if (clk_stop_req) begin
					ck_run_next = 1'b0;
					ret_dpd_next = 1'b1;
					state_next = lp_pd_pkg::ST_CLK_OFF;
				end else if (tmr_done && dpd_exit_req) begin
					cke_next = 1'b1;
					state_next = lp_pd_pkg::ST_INIT_WAIT;
				end
			end
			lp_pd_pkg::ST_CLK_OFF: begin
				if (!clk_stop_req) begin
					ck_run_next = 1'b1;
					tmr_load = 1'b1;
					tmr_val = lp_pd_pkg::CLK_STABLE_CYCLES - lp_pd_pkg::ONE;
					state_next = lp_pd_pkg::ST_CLK_ON;
				end
			end
			lp_pd_pkg::ST_CLK_ON: begin
				if (tmr_done) begin
					tmr_load = 1'b1;
					tmr_val = cke_min_cycles;
					state_next = ret_dpd_reg ? lp_pd_pkg::ST_DPD : lp_pd_pkg::ST_PD;
				end
			end
			lp_pd_pkg::ST_PD_EXIT: begin
				if (tmr_done) state_next = lp_pd_pkg::ST_ACTIVE;
			end
			lp_pd_pkg::ST_INIT_WAIT: begin
				if (init_done) state_next = lp_pd_pkg::ST_ACTIVE;
			end
			lp_pd_pkg::ST_HI_STOP: begin
				if (!clk_stop_req) begin
					ck_run_next = 1'b1;
					tmr_load = 1'b1;
					tmr_val = lp_pd_pkg::CLK_STABLE_CYCLES + xp_cycles - lp_pd_pkg::ONE;
					state_next = lp_pd_pkg::ST_HI_RESTART;
				end
			end
			lp_pd_pkg::ST_HI_RESTART: begin
				if (tmr_done) state_next = lp_pd_pkg::ST_ACTIVE;
			end
			default: state_next = lp_pd_pkg::ST_ACTIVE;
		endcase
	end

	// ==========================================================
	// registers
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= lp_pd_pkg::ST_ACTIVE;
			cke_reg <= 1'b1;
			cs_n_reg <= 1'b1;
			ca_reg <= '0;
			ck_run_reg <= 1'b1;
			ret_dpd_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cke_reg <= cke_next;
			cs_n_reg <= cs_n_next;
			ca_reg <= ca_next;
			ck_run_reg <= ck_run_next;
			ret_dpd_reg <= ret_dpd_next;
		end
	end

	assign cke = cke_reg;
	assign cs_n = cs_n_reg;
	assign ca = ca_reg;
	assign ck_run = ck_run_reg;
	assign in_power_down = (state_reg == lp_pd_pkg::ST_PD) ||
		((state_reg == lp_pd_pkg::ST_CLK_OFF || state_reg == lp_pd_pkg::ST_CLK_ON) && !ret_dpd_reg);
	assign in_deep_power_down = (state_reg == lp_pd_pkg::ST_DPD) ||
		((state_reg == lp_pd_pkg::ST_CLK_OFF || state_reg == lp_pd_pkg::ST_CLK_ON) && ret_dpd_reg);
	assign clock_stopped = !ck_run_reg;
	assign init_needed = (state_reg == lp_pd_pkg::ST_INIT_WAIT);

	// ==========================================================
	// assertions
	logic [7:0] low_run;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) low_run <= 8'h00;
		else if (cke_reg) low_run <= 8'h00;
		else if (low_run != 8'hFF) low_run <= low_run + 8'h01;
	end

	logic [7:0] high_run;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) high_run <= 8'hFF;
		else if (!cke_reg) high_run <= 8'h00;
		else if (high_run != 8'hFF) high_run <= high_run + 8'h01;
	end

	a_pd_entry_cmd: assert property (@(posedge sys_clk) disable iff (!resetn)
		(state_reg == lp_pd_pkg::ST_ACTIVE && go_pd && !go_dpd) |=> (!cke && cs_n))
		else $error("power-down entry not encoded as cke low with cs_n high");

	a_dpd_entry_cmd: assert property (@(posedge sys_clk) disable iff (!resetn)
		(state_reg == lp_pd_pkg::ST_ACTIVE && go_dpd) |=> (!cke && !cs_n && ca[2:0] == 3'h3))
		else $error("deep power-down entry encoding wrong");

	a_entry_nops: assert property (@(posedge sys_clk) disable iff (!resetn)
		($fell(cke)) |=> (!cke && cs_n) [*2])
		else $error("entry delay lacks two no-operations");

	a_cke_low_min: assert property (@(posedge sys_clk) disable iff (!resetn)
		($rose(cke)) |-> ($past(low_run) >= cke_min_cycles))
		else $error("clock enable low shorter than minimum pulse");

	a_exit_cs_high: assert property (@(posedge sys_clk) disable iff (!resetn)
		($rose(cke)) |-> cs_n)
		else $error("exit without chip select high");

	a_no_cmd_exit: assert property (@(posedge sys_clk) disable iff (!resetn)
		($rose(cke) && state_reg == lp_pd_pkg::ST_PD_EXIT) |-> (cs_n && !cmd_ready) [*2])
		else $error("command issued inside exit latency");

	a_cke_drop_ok: assert property (@(posedge sys_clk) disable iff (!resetn)
		(cke_reg && !cke_next) |-> low_ok)
		else $error("clock enable dropped while operation in progress");

	a_clk_restart: assert property (@(posedge sys_clk) disable iff (!resetn)
		($rose(ck_run) && !cke) |-> ##1 (!cke) [*2])
		else $error("exit before two stable clock cycles");

	a_stop_cs_high: assert property (@(posedge sys_clk) disable iff (!resetn)
		(!ck_run && cke) |-> cs_n)
		else $error("clock stopped with chip select low");

	a_nop_steady: assert property (@(posedge sys_clk) disable iff (!resetn)
		($changed(cke) && !cs_n) |-> !cke)
		else $error("command issued while clock enable changes");

	c_pd_cycle: cover property (@(posedge sys_clk) disable iff (!resetn)
		state_reg == lp_pd_pkg::ST_PD_EXIT ##1 state_reg == lp_pd_pkg::ST_ACTIVE);
	c_dpd_init: cover property (@(posedge sys_clk) disable iff (!resetn)
		state_reg == lp_pd_pkg::ST_INIT_WAIT ##1 state_reg == lp_pd_pkg::ST_ACTIVE);
	c_hi_stop: cover property (@(posedge sys_clk) disable iff (!resetn)
		state_reg == lp_pd_pkg::ST_HI_RESTART);
	c_lo_stop: cover property (@(posedge sys_clk) disable iff (!resetn)
		state_reg == lp_pd_pkg::ST_CLK_OFF && !ret_dpd_reg);

	// ==========================================================
	// power state assertions
	a_pd_hold_low: assert property (@(posedge sys_clk) disable iff (!resetn)
		(state_reg == lp_pd_pkg::ST_PD) |-> (!cke && cs_n))
		else $error("clock enable or chip select moved in power-down");

	a_dpd_hold_low: assert property (@(posedge sys_clk) disable iff (!resetn)
		(state_reg == lp_pd_pkg::ST_DPD) |-> (!cke && cs_n))
		else $error("clock enable or chip select moved in deep power-down");

	a_dpd_banks_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
		($fell(cke) && !cs_n) |-> $past(banks_idle))
		else $error("deep power-down entered with busy banks");

	a_dpd_code_only: assert property (@(posedge sys_clk) disable iff (!resetn)
		($fell(cke) && !cs_n) |-> (ca[2:0] == lp_pd_pkg::DPD_CA))
		else $error("chip select low on clock enable drop without deep power-down code");

	a_old_clk_kept: assert property (@(posedge sys_clk) disable iff (!resetn)
		($fell(cke)) |=> (ck_run [*2]))
		else $error("clock stopped within two cycles of clock enable drop");

	a_refresh_exit: assert property (@(posedge sys_clk) disable iff (!resetn)
		(state_reg == lp_pd_pkg::ST_PD && refresh_due && tmr_done && !clk_stop_req) |=> cke)
		else $error("power-down not left when refresh is due");

	a_dpd_exit_init: assert property (@(posedge sys_clk) disable iff (!resetn)
		($rose(cke) && $past(in_deep_power_down)) |-> init_needed)
		else $error("deep power-down exit without initialization wait");

	a_init_no_cmd: assert property (@(posedge sys_clk) disable iff (!resetn)
		init_needed |-> (!cmd_ready && cs_n))
		else $error("command accepted before initialization done");

	a_hi_restart_wait: assert property (@(posedge sys_clk) disable iff (!resetn)
		(state_reg == lp_pd_pkg::ST_HI_RESTART) |-> (!cmd_ready && cs_n && cke && ck_run))
		else $error("command accepted before clock restart wait");

	a_exit_hold_high: assert property (@(posedge sys_clk) disable iff (!resetn)
		(state_reg == lp_pd_pkg::ST_PD_EXIT) |-> (cke && cs_n))
		else $error("clock enable or chip select moved during exit latency");

	a_cke_high_min: assert property (@(posedge sys_clk) disable iff (!resetn)
		($fell(cke)) |-> ($past(high_run) >= cke_min_cycles))
		else $error("clock enable high shorter than minimum pulse");

	c_refresh_exit: cover property (@(posedge sys_clk) disable iff (!resetn)
		state_reg == lp_pd_pkg::ST_PD && refresh_due ##1 state_reg == lp_pd_pkg::ST_PD_EXIT);
endmodule : lp_power_seq

// file: lp_power_seq_dummy_guard.sv
// intentionally empty
`timescale 1ns/1ps

// file: lp_dev_model.sv
// behavioural model of the memory device low-power states
`timescale 1ns/1ps
module lp_dev_model (
	input  wire logic       sys_clk,
	input  wire logic       resetn,
	input  wire logic       cke,
	input  wire logic       cs_n,
	input  wire logic [9:0] ca,
	input  wire logic       ck_run,
	input  wire logic [7:0] xp_cycles,
	output logic            dev_pd,
	output logic            dev_dpd,
	output logic            data_kept,
	output logic [7:0]      dev_err
);
	logic       cke_reg;
	logic [1:0] ent_reg;
	logic [7:0] xp_reg;
	logic [7:0] run_reg;
	// ==========================================
	// pin decode
	wire rise   = !cke_reg && cke;
	wire fall   = cke_reg && !cke;
	wire nop_ok = cs_n || (ca[2:0] == 3'h7);
	wire cmd_on = cke && cke_reg && !nop_ok;
	wire bad    = (ent_reg != 2'h0 && !nop_ok)
		|| (rise && (!cs_n || run_reg < 8'h02))
		|| (fall && !cs_n && ca[2:0] != 3'h3)
		|| (cmd_on && (xp_reg > 8'h01 || run_reg < 8'h02));
	// ==========================================
	// state tracking
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cke_reg <= 1'b1;
			ent_reg <= 2'h0;
			xp_reg <= 8'h00;
			run_reg <= 8'h02;
			dev_pd <= 1'b0;
			dev_dpd <= 1'b0;
			data_kept <= 1'b1;
			dev_err <= 8'h00;
		end else if (!ck_run) begin
			run_reg <= 8'h00; // stopped clock, no edges reach the device
		end else begin
			cke_reg <= cke;
			run_reg <= (run_reg == 8'hFF) ? run_reg : run_reg + 8'h01;
			ent_reg <= fall ? 2'h2 : ((ent_reg == 2'h0) ? 2'h0 : ent_reg - 2'h1);
			xp_reg <= rise ? xp_cycles : ((xp_reg == 8'h00) ? 8'h00 : xp_reg - 8'h01);
			if (bad) dev_err <= dev_err + 8'h01;
			if (fall && cs_n) dev_pd <= 1'b1;
			if (fall && !cs_n && ca[2:0] == 3'h3) begin
				dev_dpd <= 1'b1;
				data_kept <= 1'b0;
			end
			if (rise) begin
				dev_pd <= 1'b0;
				dev_dpd <= 1'b0;
			end
		end
	end
endmodule : lp_dev_model

// file: tb.sv
// self-checking bench for the power-down sequencer
`timescale 1ns/1ps
module tb;
	typedef struct { logic [3:0] kind; logic csn; int gap; } case_row_s;
	localparam int RL = 6, WL = 3, DQ = 2, WR = 4, MRW = 5, IH = 2, XP = 3, CMIN = 3, RL2 = 8;
	logic       sys_clk, resetn, cmd_valid, cmd_ready, pd_req, pd_exit_req, dpd_req, dpd_exit_req;
	logic       clk_stop_req, refresh_due, banks_idle, init_done, cke, cs_n, ck_run;
	logic       in_pd, in_dpd, clk_stopped, init_needed, dev_pd, dev_dpd, data_kept;
	logic [3:0] cmd_kind;
	logic [9:0] cmd_ca, ca;
	logic [7:0] dev_err;
	logic [7:0] rl_c, wl_c, dq_c, wr_c, mrw_c, ih_c, xp_c, cmin_c;
	int         err_total, checks, cyc, n, lo;
	case_row_s  rows[9];
	// ==========================================
	// design and device model
	lp_power_seq #(.CA_W(10)) uut (.sys_clk(sys_clk), .resetn(resetn), .cmd_valid(cmd_valid),
		.cmd_kind(cmd_kind), .cmd_ca(cmd_ca), .cmd_ready(cmd_ready), .pd_req(pd_req),
		.pd_exit_req(pd_exit_req), .dpd_req(dpd_req), .dpd_exit_req(dpd_exit_req),
		.clk_stop_req(clk_stop_req), .refresh_due(refresh_due), .banks_idle(banks_idle),
		.init_done(init_done), .rl_cycles(rl_c), .wl_cycles(wl_c), .dqsck_cycles(dq_c),
		.wr_cycles(wr_c), .mrw_cycles(mrw_c), .ihcke_cycles(ih_c), .xp_cycles(xp_c),
		.cke_min_cycles(cmin_c), .cke(cke), .cs_n(cs_n), .ca(ca), .ck_run(ck_run),
		.in_power_down(in_pd), .in_deep_power_down(in_dpd), .clock_stopped(clk_stopped),
		.init_needed(init_needed));
	lp_dev_model dev (.sys_clk(sys_clk), .resetn(resetn), .cke(cke), .cs_n(cs_n), .ca(ca),
		.ck_run(ck_run), .xp_cycles(xp_c), .dev_pd(dev_pd), .dev_dpd(dev_dpd),
		.data_kept(data_kept), .dev_err(dev_err));
	// ==========================================
	// helpers
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : chk
	task automatic complete_run;
		if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	function automatic logic sig(input int s);
		case (s)
			0: return cke;
			1: return cmd_ready;
			2: return in_pd;
			3: return ck_run;
			default: return in_dpd;
		endcase
	endfunction : sig
	task automatic wait_sig(input int s, input logic v, output int k);
		k = 0;
		@(negedge sys_clk);
		while (sig(s) !== v && k < 60) begin
			@(negedge sys_clk);
			k++;
		end
		chk(k < 60, 1'b1, "wait bound");
	endtask : wait_sig
	task automatic drive_cmd(input logic [3:0] k, input logic csn);
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_ca <= {6'h15, k};
		wait_sig(1, 1'b1, n);
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		@(negedge sys_clk);
		chk(cs_n, csn, "cmd cs_n");
		if (!csn) chk(ca, {6'h15, k}, "cmd ca");
	endtask : drive_cmd
	// ==========================================
	// clock and timeout
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end
	// ==========================================
	// main sequence
	initial begin
		{resetn, cmd_valid, pd_req, pd_exit_req, dpd_req, dpd_exit_req} = 6'h00;
		{clk_stop_req, refresh_due, banks_idle, init_done} = 4'h0;
		cmd_kind = 4'h0;
		cmd_ca = 10'h000;
		{rl_c, wl_c, dq_c, wr_c} = {8'(RL), 8'(WL), 8'(DQ), 8'(WR)};
		{mrw_c, ih_c, xp_c, cmin_c} = {8'(MRW), 8'(IH), 8'(XP), 8'(CMIN)};
		rows = '{'{4'h0, 1'b1, 0}, '{4'h1, 1'b0, RL + DQ + 5}, '{4'h2, 1'b0, WL + 5 + WR},
			'{4'h3, 1'b0, WL + 6 + WR}, '{4'h4, 1'b0, RL + DQ + 5}, '{4'h5, 1'b0, MRW},
			'{4'h6, 1'b0, IH}, '{4'h7, 1'b0, IH}, '{4'h8, 1'b0, IH}};
		repeat (10) @(posedge sys_clk);
		chk({cke, cs_n, ck_run, cmd_ready}, 4'hF, "reset pins");
		resetn <= 1'b1;
		foreach (rows[i]) begin
			drive_cmd(rows[i].kind, rows[i].csn);
			@(posedge sys_clk);
			pd_req <= 1'b1;
			wait_sig(0, 1'b0, n);
			chk(n + 1 >= rows[i].gap, 1'b1, "cke spacing");
			chk(n + 1 <= rows[i].gap + 4, 1'b1, "cke late");
			chk(cs_n, 1'b1, "pd entry cs_n");
			repeat (2) begin
				@(negedge sys_clk);
				chk({cke, cs_n}, 2'h1, "entry nop");
			end
			wait_sig(2, 1'b1, lo);
			chk(dev_pd, 1'b1, "device pd");
			@(posedge sys_clk);
			pd_req <= 1'b0;
			pd_exit_req <= 1'b1;
			wait_sig(0, 1'b1, n);
			chk(lo + n + 3 >= CMIN, 1'b1, "cke low time");
			chk(cs_n, 1'b1, "exit cs_n");
			@(posedge sys_clk);
			pd_exit_req <= 1'b0;
			wait_sig(1, 1'b1, n);
			chk(n + 1 >= XP, 1'b1, "exit latency");
			chk(cke, 1'b1, "cke held");
		end
		@(posedge sys_clk);
		pd_req <= 1'b1;
		wait_sig(2, 1'b1, n);
		@(posedge sys_clk);
		pd_req <= 1'b0;
		clk_stop_req <= 1'b1;
		wait_sig(3, 1'b0, n);
		chk({cke, in_pd, clk_stopped}, 3'h3, "pd clock stop");
		@(posedge sys_clk);
		clk_stop_req <= 1'b0;
		refresh_due <= 1'b1;
		wait_sig(0, 1'b1, n);
		chk(n >= 2 + CMIN, 1'b1, "pd restart wait");
		@(posedge sys_clk);
		refresh_due <= 1'b0;
		wait_sig(1, 1'b1, n);
		@(posedge sys_clk);
		dpd_req <= 1'b1;
		repeat (20) @(negedge sys_clk);
		chk(cke, 1'b1, "dpd banks busy");
		@(posedge sys_clk);
		banks_idle <= 1'b1;
		wait_sig(0, 1'b0, n);
		chk({cs_n, ca}, 11'h003, "dpd entry");
		repeat (2) begin
			@(negedge sys_clk);
			chk({cke, cs_n}, 2'h1, "dpd nop");
		end
		wait_sig(4, 1'b1, n);
		chk({dev_dpd, data_kept}, 2'h2, "dpd device");
		@(posedge sys_clk);
		dpd_req <= 1'b0;
		clk_stop_req <= 1'b1;
		wait_sig(3, 1'b0, n);
		chk({cke, clk_stopped}, 2'h1, "low clock stop");
		@(posedge sys_clk);
		clk_stop_req <= 1'b0;
		wait_sig(3, 1'b1, n);
		@(posedge sys_clk);
		dpd_exit_req <= 1'b1;
		wait_sig(0, 1'b1, n);
		chk({init_needed, cmd_ready}, 2'h2, "dpd exit");
		@(posedge sys_clk);
		dpd_exit_req <= 1'b0;
		init_done <= 1'b1;
		@(posedge sys_clk);
		init_done <= 1'b0;
		wait_sig(1, 1'b1, n);
		@(posedge sys_clk);
		clk_stop_req <= 1'b1;
		wait_sig(3, 1'b0, n);
		chk({cke, cs_n}, 2'h3, "high clock stop");
		@(posedge sys_clk);
		clk_stop_req <= 1'b0;
		wait_sig(3, 1'b1, n);
		wait_sig(1, 1'b1, n);
		chk(n + 1 >= 2 + XP, 1'b1, "restart ready");
		@(posedge sys_clk);
		rl_c <= 8'(RL2);
		drive_cmd(4'h1, 1'b0);
		@(posedge sys_clk);
		pd_req <= 1'b1;
		wait_sig(0, 1'b0, n);
		chk(n + 1, RL2 + DQ + 5, "new read spacing");
		@(posedge sys_clk);
		pd_req <= 1'b1;
		wait_sig(2, 1'b1, n);
		chk(dev_err, 8'h00, "device rule faults");
		@(posedge sys_clk);
		resetn <= 1'b0;
		pd_req <= 1'b0;
		@(negedge sys_clk);
		chk({cke, cs_n, ck_run, in_pd}, 4'hE, "mid reset");
		@(posedge sys_clk);
		resetn <= 1'b1;
		@(negedge sys_clk);
		chk({cke, cs_n, cmd_ready, in_pd}, 4'hE, "reset release");
		drive_cmd(4'h6, 1'b0);
		chk(dev_err, 8'h00, "device faults after reset");
		complete_run();
	end
endmodule : tb
